/* hw/pmb_pkg.sv */
package pmb_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          MS_NS         = 1000000;
	localparam int          MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          PRE_W         = 15;
	localparam logic [9:0]  MS_PER_S      = 10'h3e8;
	localparam logic [12:0] CNT_SAT       = 13'h1fff;

	// ----------------------------------------------------------------
	// Parameter limits (skew in ms, mute time in s)
	// ----------------------------------------------------------------
	localparam logic [15:0] SKEW_MAX_MS   = 16'h0fa0;
	localparam int          MUTE_MAX_MIN  = 120;
	localparam logic [15:0] MUTE_MAX_S    = 16'(MUTE_MAX_MIN * 60);

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_SKEW      = 8'h04;
	localparam logic [7:0]  REG_MTIME     = 8'h08;
	localparam logic [7:0]  REG_STATUS    = 8'h0c;
	localparam int          CTRL_ACTIVATE = 0;
	localparam int          CTRL_AUTO_ACK = 1;
	localparam int          CTRL_RESET    = 2;
	localparam logic [15:0] RST_SKEW      = 16'h0000;
	localparam logic [15:0] RST_MTIME     = 16'h0000;

	// ----------------------------------------------------------------
	// States, Gray along idle-init-safe-entry-muted
	// ----------------------------------------------------------------
	typedef enum logic [3:0]
	{
		ST_IDLE    = 4'h0,
		ST_INIT    = 4'h1,
		ST_SAFE    = 4'h3,
		ST_ENTRY_A = 4'h2,
		ST_MUTED   = 4'h6,
		ST_ENTRY_B = 4'h7,
		ST_DEMAND  = 4'h5,
		ST_WAITACK = 4'h4,
		ST_ERR_SEQ = 4'hc,
		ST_ERR_TMR = 4'hd,
		ST_ERR_PAR = 4'hf
	} pmb_state_e;

	// ----------------------------------------------------------------
	// Diagnostic codes
	// ----------------------------------------------------------------
	localparam logic [15:0] DG_IDLE    = 16'h0000;
	localparam logic [15:0] DG_INIT    = 16'h8001;
	localparam logic [15:0] DG_SAFE    = 16'h8000;
	localparam logic [15:0] DG_ENTRY_A = 16'h8010;
	localparam logic [15:0] DG_ENTRY_B = 16'h8310;
	localparam logic [15:0] DG_MUTED   = 16'h8020;
	localparam logic [15:0] DG_DEMAND  = 16'h8002;
	localparam logic [15:0] DG_WAITACK = 16'h8003;
	localparam logic [15:0] DG_ERR_SEQ = 16'hc002;
	localparam logic [15:0] DG_ERR_TMR = 16'hc003;
	localparam logic [15:0] DG_ERR_PAR = 16'hc004;

endpackage

/* hw/pmb_tmr_if.sv */
`timescale 1ns/1ps
interface pmb_tmr_if;
	logic        skew_run;
	logic        mute_run;
	logic [15:0] skew_limit;
	logic [15:0] mute_limit;
	logic        skew_expired;
	logic        mute_expired;

	modport ctl
	(
		output skew_run, mute_run, skew_limit, mute_limit,
		input  skew_expired, mute_expired
	);
	modport tmr
	(
		input  skew_run, mute_run, skew_limit, mute_limit,
		output skew_expired, mute_expired
	);
endinterface

/* hw/pmb_timer.sv */
`timescale 1ns/1ps
module pmb_timer
#(
	parameter int MS_CYCLES = pmb_pkg::MS_CYCLES
)
(
	input  wire logic pclk,
	input  wire logic presetn,
	pmb_tmr_if.tmr    t
);

	typedef struct packed
	{
		logic [pmb_pkg::PRE_W-1:0] pre;
		logic [12:0]               skew_ms;
		logic [9:0]                sec_ms;
		logic [12:0]               mute_s;
	} pmb_tmr_s;

	pmb_tmr_s r;
	pmb_tmr_s next_r;
	logic     ms_tick;

	// The prescaler runs free; a run may therefore start up to 1 ms early
	// within its first tick, which only makes the limits stricter.
	assign ms_tick = (r.pre == pmb_pkg::PRE_W'(MS_CYCLES - 1));

	always_comb
	begin
		next_r = r;
		next_r.pre = ms_tick ? '0 : r.pre + 1'b1;
		if (!t.skew_run)
			next_r.skew_ms = '0;
		else if (ms_tick && r.skew_ms != pmb_pkg::CNT_SAT)
			next_r.skew_ms = r.skew_ms + 1'b1;
		if (!t.mute_run)
		begin
			next_r.sec_ms = '0;
			next_r.mute_s = '0;
		end
		else if (ms_tick)
		begin
			if (r.sec_ms == pmb_pkg::MS_PER_S - 1'b1)
			begin
				next_r.sec_ms = '0;
				if (r.mute_s != pmb_pkg::CNT_SAT)
					next_r.mute_s = r.mute_s + 1'b1;
			end
			else
				next_r.sec_ms = r.sec_ms + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '0;
		else
			r <= next_r;
	end

	assign t.skew_expired = t.skew_run && ({3'h0, r.skew_ms} >= t.skew_limit);
	assign t.mute_expired = t.mute_run && ({3'h0, r.mute_s} >= t.mute_limit);

endmodule

/* hw/pmb_parallel_mute_block.sv */
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module pmb_parallel_mute_block
#(
	parameter int MS_CYCLES = pmb_pkg::MS_CYCLES
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        guard_ossd_in,
	input  wire logic        mute_sensor_a,
	input  wire logic        mute_sensor_b,
	input  wire logic        mute_permit,
	output logic             ready_out,
	output logic             guard_ok_out,
	output logic             mute_on_out,
	output logic             protect_request_out,
	output logic             ack_request_out,
	output logic             error_out,
	output logic [15:0]      diag_word
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic ready;
		logic guard_ok;
		logic mute_on;
		logic protect;
		logic ack_req;
		logic error;
		logic [15:0] diag;
	} pmb_out_s;

	typedef struct packed
	{
		pmb_pkg::pmb_state_e st;
		logic                a_q;
		logic                b_q;
		logic                rst_q;
		logic                activate;
		logic                auto_ack;
		logic                op_reset;
		logic [15:0]         skew_lim;
		logic [15:0]         mute_lim;
		logic [31:0]         rdata;
		logic                rerr;
		pmb_out_s            o;
	} pmb_state_s;

	pmb_state_s r;
	pmb_state_s next_r;
	pmb_tmr_if  tif ();

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == pmb_pkg::REG_CTRL) || (a == pmb_pkg::REG_SKEW) ||
			(a == pmb_pkg::REG_MTIME) || (a == pmb_pkg::REG_STATUS);
	endfunction

	function automatic pmb_out_s outs(input pmb_pkg::pmb_state_e s, input logic clr);
		outs = '0;
		outs.ready = (s != pmb_pkg::ST_IDLE);
		case (s)
			pmb_pkg::ST_IDLE:
				outs.diag = pmb_pkg::DG_IDLE;
			pmb_pkg::ST_INIT:
			begin
				outs.ack_req = 1'b1;
				outs.diag = pmb_pkg::DG_INIT;
			end
			pmb_pkg::ST_SAFE:
			begin
				outs.guard_ok = 1'b1;
				outs.diag = pmb_pkg::DG_SAFE;
			end
			pmb_pkg::ST_ENTRY_A:
			begin
				outs.guard_ok = 1'b1;
				outs.diag = pmb_pkg::DG_ENTRY_A;
			end
			pmb_pkg::ST_ENTRY_B:
			begin
				outs.guard_ok = 1'b1;
				outs.diag = pmb_pkg::DG_ENTRY_B;
			end
			pmb_pkg::ST_MUTED:
			begin
				outs.guard_ok = 1'b1;
				outs.mute_on = 1'b1;
				outs.diag = pmb_pkg::DG_MUTED;
			end
			pmb_pkg::ST_DEMAND:
			begin
				outs.protect = 1'b1;
				outs.diag = pmb_pkg::DG_DEMAND;
			end
			pmb_pkg::ST_WAITACK:
			begin
				outs.ack_req = 1'b1;
				outs.diag = pmb_pkg::DG_WAITACK;
			end
			pmb_pkg::ST_ERR_SEQ:
			begin
				outs.error = 1'b1;
				outs.ack_req = clr;
				outs.diag = pmb_pkg::DG_ERR_SEQ;
			end
			pmb_pkg::ST_ERR_TMR:
			begin
				outs.error = 1'b1;
				outs.ack_req = clr;
				outs.diag = pmb_pkg::DG_ERR_TMR;
			end
			pmb_pkg::ST_ERR_PAR:
			begin
				outs.error = 1'b1;
				outs.ack_req = clr;
				outs.diag = pmb_pkg::DG_ERR_PAR;
			end
			default:
				outs = '0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Sequencing
	// ----------------------------------------------------------------
	logic a_rise;
	logic b_rise;
	logic rst_edge;
	logic par_bad;
	logic cleared;
	logic wrong_seq;
	logic wr_acc;
	logic setup;
	pmb_pkg::pmb_state_e ns;

	assign a_rise   = mute_sensor_a && !r.a_q;
	assign b_rise   = mute_sensor_b && !r.b_q;
	assign rst_edge = r.op_reset && !r.rst_q;
	assign par_bad  = (r.skew_lim > pmb_pkg::SKEW_MAX_MS) ||
		(r.mute_lim > pmb_pkg::MUTE_MAX_S);
	// Sensors must be released before a lockout can be acknowledged
	assign cleared  = !par_bad && !mute_sensor_a && !mute_sensor_b;
	assign wrong_seq = (a_rise && mute_sensor_b && !b_rise) ||
		(b_rise && mute_sensor_a && !a_rise) ||
		(mute_sensor_a && !a_rise && mute_sensor_b && !b_rise) ||
		(!mute_permit && (a_rise || b_rise));

	assign tif.skew_run   = (r.st == pmb_pkg::ST_ENTRY_A) || (r.st == pmb_pkg::ST_ENTRY_B);
	assign tif.mute_run   = tif.skew_run || (r.st == pmb_pkg::ST_MUTED);
	assign tif.skew_limit = r.skew_lim;
	assign tif.mute_limit = r.mute_lim;

	always_comb
	begin
		ns = r.st;
		if (!r.activate)
			ns = pmb_pkg::ST_IDLE;
		else if (par_bad && r.st != pmb_pkg::ST_IDLE)
			ns = pmb_pkg::ST_ERR_PAR;
		else
		begin
			case (r.st)
				pmb_pkg::ST_IDLE:
					ns = pmb_pkg::ST_INIT;
				pmb_pkg::ST_INIT:
					if (r.auto_ack || rst_edge)
						ns = pmb_pkg::ST_SAFE;
				pmb_pkg::ST_SAFE:
					if (wrong_seq)
						ns = pmb_pkg::ST_ERR_SEQ;
					else if (!guard_ossd_in)
						ns = pmb_pkg::ST_DEMAND;
					else if (a_rise && b_rise)
						ns = pmb_pkg::ST_MUTED;
					else if (a_rise)
						ns = pmb_pkg::ST_ENTRY_A;
					else if (b_rise)
						ns = pmb_pkg::ST_ENTRY_B;
				pmb_pkg::ST_ENTRY_A:
					if (!mute_permit || !mute_sensor_a)
						ns = pmb_pkg::ST_ERR_SEQ;
					else if (tif.skew_expired || tif.mute_expired)
						ns = pmb_pkg::ST_ERR_TMR;
					else if (!guard_ossd_in)
						ns = pmb_pkg::ST_DEMAND;
					else if (b_rise)
						ns = pmb_pkg::ST_MUTED;
				pmb_pkg::ST_ENTRY_B:
					if (!mute_permit || !mute_sensor_b)
						ns = pmb_pkg::ST_ERR_SEQ;
					else if (tif.skew_expired || tif.mute_expired)
						ns = pmb_pkg::ST_ERR_TMR;
					else if (!guard_ossd_in)
						ns = pmb_pkg::ST_DEMAND;
					else if (a_rise)
						ns = pmb_pkg::ST_MUTED;
				pmb_pkg::ST_MUTED:
					// Permit and guard are ignored here by intent
					if (tif.mute_expired)
						ns = pmb_pkg::ST_ERR_TMR;
					else if (!mute_sensor_a || !mute_sensor_b)
						ns = pmb_pkg::ST_SAFE;
				pmb_pkg::ST_DEMAND:
					if (guard_ossd_in)
						ns = pmb_pkg::ST_WAITACK;
				pmb_pkg::ST_WAITACK:
					if (!guard_ossd_in)
						ns = pmb_pkg::ST_DEMAND;
					else if (rst_edge)
						ns = pmb_pkg::ST_SAFE;
				pmb_pkg::ST_ERR_SEQ,
				pmb_pkg::ST_ERR_TMR,
				pmb_pkg::ST_ERR_PAR:
					if (cleared && rst_edge)
						ns = pmb_pkg::ST_SAFE;
				default:
					ns = pmb_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// APB slave and next state
	// ----------------------------------------------------------------
	assign setup  = psel && !penable;
	assign wr_acc = psel && penable && pwrite && reg_hit(paddr);

	always_comb
	begin
		next_r = r;
		next_r.st = ns;
		next_r.a_q = mute_sensor_a;
		next_r.b_q = mute_sensor_b;
		next_r.rst_q = r.op_reset;
		next_r.o = outs(ns, (ns == r.st) ? cleared : 1'b0);
		if (setup)
		begin
			next_r.rerr = !reg_hit(paddr);
			next_r.rdata = '0;
			case (paddr)
				pmb_pkg::REG_CTRL:
				begin
					next_r.rdata[pmb_pkg::CTRL_ACTIVATE] = r.activate;
					next_r.rdata[pmb_pkg::CTRL_AUTO_ACK] = r.auto_ack;
					next_r.rdata[pmb_pkg::CTRL_RESET] = r.op_reset;
				end
				pmb_pkg::REG_SKEW:
					next_r.rdata[15:0] = r.skew_lim;
				pmb_pkg::REG_MTIME:
					next_r.rdata[15:0] = r.mute_lim;
				pmb_pkg::REG_STATUS:
					next_r.rdata = {r.o.diag, 4'h0, r.st, 2'h0, r.o.error,
						r.o.ack_req, r.o.protect, r.o.mute_on, r.o.guard_ok, r.o.ready};
				default:
					next_r.rdata = '0;
			endcase
		end
		if (wr_acc)
		begin
			case (paddr)
				pmb_pkg::REG_CTRL:
				begin
					next_r.activate = pwdata[pmb_pkg::CTRL_ACTIVATE];
					next_r.auto_ack = pwdata[pmb_pkg::CTRL_AUTO_ACK];
					next_r.op_reset = pwdata[pmb_pkg::CTRL_RESET];
				end
				pmb_pkg::REG_SKEW:
					next_r.skew_lim = pwdata[15:0];
				pmb_pkg::REG_MTIME:
					next_r.mute_lim = pwdata[15:0];
				default:
					next_r.skew_lim = r.skew_lim;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r <= '0;
			r.st <= pmb_pkg::ST_IDLE;
			r.skew_lim <= pmb_pkg::RST_SKEW;
			r.mute_lim <= pmb_pkg::RST_MTIME;
		end
		else
			r <= next_r;
	end

	pmb_timer
	#(
		.MS_CYCLES (MS_CYCLES)
	)
	u_timer
	(
		.pclk    (pclk),
		.presetn (presetn),
		.t       (tif)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign pready              = 1'b1;
	assign pslverr             = psel && penable && r.rerr;
	assign prdata              = r.rdata;
	assign ready_out           = r.o.ready;
	assign guard_ok_out        = r.o.guard_ok;
	assign mute_on_out         = r.o.mute_on;
	assign protect_request_out = r.o.protect;
	assign ack_request_out     = r.o.ack_req;
	assign error_out           = r.o.error;
	assign diag_word           = r.o.diag;

endmodule

/* testbench/pmb_mute_properties.sv */
`timescale 1ns/1ps
module pmb_mute_properties
#(
	parameter int MS_CYCLES = 4
)
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        guard_ossd_in,
	input wire logic        mute_sensor_a,
	input wire logic        mute_sensor_b,
	input wire logic        mute_permit,
	input wire logic        ready_out,
	input wire logic        guard_ok_out,
	input wire logic        mute_on_out,
	input wire logic        protect_request_out,
	input wire logic        ack_request_out,
	input wire logic        error_out,
	input wire logic [15:0] diag_word
);
	// ----------------------------------------------------------------
	// Pin relations; a state change shows one edge after its cause
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	mute_needs_both_a: assert property ($rose(mute_on_out) |->
		$past(mute_sensor_a) && $past(mute_sensor_b)) else $error("mute without both sensors");
	mute_start_gate_a: assert property ($rose(mute_on_out) |->
		$past(guard_ossd_in) && $past(mute_permit)) else $error("mute on cut field or no permit");
	mute_ends_release_a: assert property (mute_on_out && !(mute_sensor_a && mute_sensor_b)
		|=> !mute_on_out) else $error("mute held after sensor release");
	mute_holds_a: assert property (mute_on_out && mute_sensor_a && mute_sensor_b |=>
		mute_on_out || error_out || !ready_out) else $error("mute dropped with sensors held");
	muted_shown_a: assert property (mute_on_out |-> guard_ok_out &&
		diag_word == pmb_pkg::DG_MUTED) else $error("muted state not shown");
	cut_field_drop_a: assert property (guard_ok_out && !mute_on_out && !guard_ossd_in |=>
		!guard_ok_out) else $error("guard ok kept on cut field");
	entry_abort_a: assert property (diag_word == pmb_pkg::DG_ENTRY_A &&
		(!mute_sensor_a || !mute_permit) |=> error_out || !ready_out)
		else $error("entry kept after bad sequence");
	error_outputs_a: assert property (error_out |-> !guard_ok_out && !mute_on_out
		&& diag_word[15:14] == 2'h3) else $error("error outputs wrong");
	error_exit_a: assert property ($fell(error_out) |-> !ready_out ||
		guard_ok_out && $past(ack_request_out)) else $error("error left without reset");
	idle_quiet_a: assert property (!ready_out |-> !guard_ok_out && !error_out
		&& diag_word == 16'h0000) else $error("idle outputs not quiet");

	cover property ($rose(mute_on_out));
	cover property ($rose(protect_request_out));
	cover property ($fell(error_out));
endmodule

bind pmb_parallel_mute_block pmb_mute_properties #(.MS_CYCLES(MS_CYCLES)) chk_u
(
	.pclk, .presetn, .guard_ossd_in, .mute_sensor_a, .mute_sensor_b, .mute_permit,
	.ready_out, .guard_ok_out, .mute_on_out, .protect_request_out, .ack_request_out,
	.error_out, .diag_word
);

/* testbench/pmb_field_model.sv */
`timescale 1ns/1ps
module pmb_field_model
(
	input  wire logic pclk,
	input  wire logic go,
	input  wire logic first_b,
	input  wire logic permit_en,
	input  wire logic brk,
	input  wire logic field_cut,
	input  int        skew,
	input  int        dwell,
	output logic      busy,
	output logic      guard_ossd_in,
	output logic      mute_sensor_a,
	output logic      mute_sensor_b,
	output logic      mute_permit
);
	// ----------------------------------------------------------------
	// One workpiece passing the gate, timed from go
	// ----------------------------------------------------------------
	int   t = 0;
	logic s1;
	logic s2;

	always @(posedge pclk)
		t <= go ? 1 : (t == 0 || t > skew + dwell + 4) ? 0 : t + 1;

	// Both sensors stay actuated through the dwell; a negative dwell drops the first early
	assign s1 = t >= 1 && t < 1 + skew + dwell;
	assign s2 = t >= 1 + skew && t < 3 + skew + dwell;
	assign mute_sensor_a = first_b ? s2 : s1;
	assign mute_sensor_b = first_b ? s1 : s2;
	// Control withdraws the permit once muting is under way
	assign mute_permit = permit_en && t < 2 + skew;
	// The load itself cuts the field while muted; field_cut is a standing obstruction
	assign guard_ossd_in = !field_cut && !(brk && t >= 2 + skew && t < 5 + skew);
	assign busy = t != 0;
endmodule

/* testbench/pmb_parallel_mute_block_tb.sv */
`timescale 1ns/1ps
module pmb_parallel_mute_block_tb;
	localparam int MSC = 4;
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, e, busy;
	logic        guard_ossd_in, mute_sensor_a, mute_sensor_b, mute_permit;
	logic        ready_out, guard_ok_out, mute_on_out, protect_request_out;
	logic        ack_request_out, error_out;
	logic [15:0] diag_word;
	logic        go = 1'h0, first_b = 1'h0, permit_en = 1'h0, brk = 1'h0, field_cut = 1'h0;
	int          skew = 0, dwell = 4, fail_count = 0, n_compared = 0;

	always #25 pclk = ~pclk;

	pmb_parallel_mute_block #(.MS_CYCLES(MSC)) dut_u
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .guard_ossd_in, .mute_sensor_a, .mute_sensor_b, .mute_permit, .ready_out,
		.guard_ok_out, .mute_on_out, .protect_request_out, .ack_request_out, .error_out,
		.diag_word
	);
	pmb_field_model mdl_u
	(
		.pclk, .go, .first_b, .permit_en, .brk, .field_cut, .skew, .dwell, .busy,
		.guard_ossd_in, .mute_sensor_a, .mute_sensor_b, .mute_permit
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tk(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 16);
		if (pready !== 1'h1)
		begin
			fail_count++;
			end_of_test();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// Operator reset acts on the 0 to 1 change only, so it is written high then low
	task automatic ack_pulse;
		apb(1'h1, pmb_pkg::REG_CTRL, 32'h5);
		apb(1'h1, pmb_pkg::REG_CTRL, 32'h1);
		tk(1);
	endtask

	function automatic logic [15:0] exp_diag(input int sk, input int dw, input logic pe);
		if (!pe)
			return pmb_pkg::DG_ERR_SEQ;
		if (sk > 40 * MSC || dw > 1000 * MSC)
			return pmb_pkg::DG_ERR_TMR;
		return pmb_pkg::DG_SAFE;
	endfunction

	task automatic transit(input int sk, input int dw, input logic fb, input logic pe,
		input logic bk, input logic [15:0] ed, input logic em);
		int   n;
		logic seen;
		@(posedge pclk);
		skew <= sk;
		dwell <= dw;
		first_b <= fb;
		permit_en <= pe;
		brk <= bk;
		go <= 1'h1;
		@(posedge pclk);
		go <= 1'h0;
		seen = 1'h0;
		n = 0;
		do
		begin
			tk(1);
			seen |= mute_on_out;
			n++;
		end
		while (busy === 1'h1 && n < 8000);
		if (busy === 1'h1)
		begin
			fail_count++;
			end_of_test();
		end
		check("muted", seen, em);
		check("diag", diag_word, ed);
		if (ed[15:14] == 2'h3)
		begin
			check("ack", ack_request_out, 1'h1);
			ack_pulse();
			check("rearm", diag_word, pmb_pkg::DG_SAFE);
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		int   sk;
		int   dw;
		logic fb;
		logic bk;
		void'($urandom(46));
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		tk(1);
		check("outs", {ready_out, guard_ok_out, mute_on_out, protect_request_out,
			ack_request_out, error_out, diag_word}, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			apb(1'h0, 8'(4 * i), 32'h0);
			check("regrst", q, 32'h0);
		end
		apb(1'h0, 8'h10, 32'h0);
		check("slverr", {31'h0, e}, 32'h1);
		check("unmapped", q, 32'h0);
		apb(1'h1, pmb_pkg::REG_SKEW, 32'h28);
		apb(1'h1, pmb_pkg::REG_MTIME, 32'h1);
		apb(1'h1, pmb_pkg::REG_CTRL, 32'h1);
		tk(1);
		check("init", {ack_request_out, ready_out, diag_word}, {2'h3, pmb_pkg::DG_INIT});
		ack_pulse();
		apb(1'h0, pmb_pkg::REG_STATUS, 32'h0);
		check("status", {q[31:16], q[5:0]}, {pmb_pkg::DG_SAFE, 6'h03});
		transit(0, 10, 1'h0, 1'h1, 1'h1, pmb_pkg::DG_SAFE, 1'h1);
		transit(1, 4, 1'h1, 1'h1, 1'h0, pmb_pkg::DG_SAFE, 1'h1);
		transit(10, -5, 1'h0, 1'h1, 1'h0, pmb_pkg::DG_ERR_SEQ, 1'h0);
		transit(300, 10, 1'h0, 1'h1, 1'h0, pmb_pkg::DG_ERR_TMR, 1'h0);
		transit(5, 6000, 1'h1, 1'h1, 1'h0, pmb_pkg::DG_ERR_TMR, 1'h1);
		transit(2, 10, 1'h0, 1'h0, 1'h0, pmb_pkg::DG_ERR_SEQ, 1'h0);
		repeat (8)
		begin
			sk = $urandom_range(60, 0);
			dw = $urandom_range(100, 4);
			fb = 1'($urandom_range(1, 0));
			bk = 1'($urandom_range(1, 0));
			transit(sk, dw, fb, 1'h1, bk, exp_diag(sk, dw, 1'h1), 1'h1);
		end
		@(posedge pclk);
		field_cut <= 1'h1;
		tk(1);
		check("demand", {protect_request_out, guard_ok_out, diag_word},
			{2'h2, pmb_pkg::DG_DEMAND});
		transit(0, 10, 1'h0, 1'h1, 1'h0, pmb_pkg::DG_DEMAND, 1'h0);
		@(posedge pclk);
		field_cut <= 1'h0;
		tk(2);
		check("waitack", {ack_request_out, diag_word}, {1'h1, pmb_pkg::DG_WAITACK});
		ack_pulse();
		check("resume", diag_word, pmb_pkg::DG_SAFE);
		for (int i = 0; i < 2; i++)
		begin
			apb(1'h1, i ? pmb_pkg::REG_MTIME : pmb_pkg::REG_SKEW, i ? 32'h1c20 : 32'h0fa0);
			tk(2);
			check("edge_ok", error_out, 1'h0);
			apb(1'h1, i ? pmb_pkg::REG_MTIME : pmb_pkg::REG_SKEW, i ? 32'h1c21 : 32'h0fa1);
			tk(2);
			check("par_err", {error_out, guard_ok_out, mute_on_out, diag_word},
				{3'h4, pmb_pkg::DG_ERR_PAR});
			apb(1'h1, i ? pmb_pkg::REG_MTIME : pmb_pkg::REG_SKEW, i ? 32'h1 : 32'h28);
			ack_pulse();
			check("par_clr", diag_word, pmb_pkg::DG_SAFE);
		end
		apb(1'h1, pmb_pkg::REG_CTRL, 32'h0);
		tk(1);
		check("idle", {ready_out, guard_ok_out, error_out, diag_word}, 32'h0);
		apb(1'h1, pmb_pkg::REG_CTRL, 32'h3);
		tk(2);
		check("autoack", diag_word, pmb_pkg::DG_SAFE);
		end_of_test();
	end
endmodule
